// file: hdl/cfg_loader_pkg.sv
// Purpose: shared constants of the fabric programming link
// Assumes: 32-bit register words, byte addresses
// Notes: device map first, then the loader controller's own map
package cfg_loader_pkg;
    // device register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    // control register fields
    localparam int CTRL_LOAD_BIT = 0;
    localparam int CTRL_PUSH_BIT = 1;
    localparam int CTRL_RST_BIT = 2;
    localparam int CTRL_RDBK_BIT = 3;
    localparam int CTRL_DATA_LSB = 16;
    localparam int CFG_WORD_W = 16;
    // status register fields
    localparam int CONN_N = 4;
    localparam int STAT_EN_LSB = 0;
    localparam int STAT_LOADED_BIT = 8;
    localparam int STAT_RDONE_BIT = 9;
    localparam int STAT_DEV_BIT = 10;
    localparam int STAT_RBUSY_BIT = 11;
    // connection groups behind the enable bits
    localparam int CONN_BUS = 0;
    localparam int CONN_IO = 3;
    // image size
    localparam int CFG_BYTES = 32768;
    localparam int CFG_WORDS = CFG_BYTES / (CFG_WORD_W / 8);
    // emulation pin groups
    localparam int IRQ_N = 4;
    localparam int DMA_N = 4;
    localparam int FAB_IO_W = 112;
    localparam int GP_W = 48;
    // fabric reset pulse
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAB_RST_NS = 100;
    localparam int FAB_RST_CYC = (FAB_RST_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // loader controller map
    localparam logic [3:0] HCMD_OFS = 4'h0;
    localparam logic [3:0] HSTAT_OFS = 4'h4;
    localparam logic [3:0] HCNT_OFS = 4'h8;
    localparam int HCMD_LOAD_BIT = 0;
    localparam int HCMD_RST_BIT = 1;
    localparam int HCMD_EN_BIT = 2;
    localparam int HCMD_EN_LSB = 8;
    localparam int HSTAT_BUSY_BIT = 0;
    localparam int HSTAT_DEV_LSB = 16;
endpackage

// file: hdl/cfg_link_if.sv
// Purpose: register link between loader controller and programming port
// Assumes: one clock, read data one cycle after the read strobe
// Notes: read strobes are single-cycle, writes may run back to back; the two strobes are never both high
`timescale 1ns/1ns
`default_nettype none
interface cfg_link_if;
    logic [cfg_loader_pkg::ADDR_W-1:0] addr;
    logic [cfg_loader_pkg::DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [cfg_loader_pkg::DATA_W-1:0] rdata;
    // programming port end
    modport dev (input addr, input wdata, input wr, input rd,
        output rdata);
    // loader controller end
    modport host (output addr, output wdata, output wr, output rd,
        input rdata);
endinterface
`default_nettype wire

// file: hdl/fabric_prog_if.sv
// Purpose: programming port of the customizable logic fabric
// Assumes: single clock, link master keeps the strobe discipline
// Notes: pads use active-low output enables
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: high configuration pin selects development mode
// R2: development mode turns pins into bus ports
// R3: external logic gets bus, 4 irq, 4 dma
// R4: 112 dedicated I/O lines reach external FPGA
// R5: software downloads image, then starts connections
// R6: download and startup steered by control register
// R7: every cell loaded with its image word
// R8: image data moves through control register high bits
// R9: software supplies full 32 KByte image
// R10: fabric reset before any connection allowed
// R11: only status-enabled connections are made
// R12: port holds download path, reset, control register
// R13: low pin keeps normal pin function
// R14: connections stay off until software enables
module fabric_prog_if #(
    parameter int CFG_WORDS = cfg_loader_pkg::CFG_WORDS,
    parameter int RST_CYC = cfg_loader_pkg::FAB_RST_CYC,
    parameter int GP_W = cfg_loader_pkg::GP_W,
    parameter int IO_W = cfg_loader_pkg::FAB_IO_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register link
    cfg_link_if.dev link,
    // configuration pin
    input wire logic dev_cfg_pin,
    // fabric cell loading and control
    output logic cell_we,
    output logic [$clog2(CFG_WORDS)-1:0] cell_addr,
    output logic [cfg_loader_pkg::CFG_WORD_W-1:0] cell_data,
    output logic fab_rst,
    output logic [cfg_loader_pkg::CONN_N-1:0] conn_en,
    output logic dev_mode,
    // general-purpose pads
    input wire logic [GP_W-1:0] gp_pad_in,
    output logic [GP_W-1:0] gp_pad_out,
    output logic [GP_W-1:0] gp_pad_oe_n,
    // normal pin function from the chip
    input wire logic [GP_W-1:0] chip_gp_out,
    input wire logic [GP_W-1:0] chip_gp_oe_n,
    output logic [GP_W-1:0] chip_gp_in,
    // emulation bus bundle
    input wire logic [GP_W-9:0] emu_tx,
    input wire logic [GP_W-9:0] emu_tx_oe_n,
    output logic [GP_W-9:0] emu_rx,
    output logic [cfg_loader_pkg::IRQ_N-1:0] emu_irq,
    output logic [cfg_loader_pkg::DMA_N-1:0] emu_dma,
    // dedicated fabric I/O pads
    input wire logic [IO_W-1:0] io_pad_in,
    output logic [IO_W-1:0] io_pad_out,
    output logic [IO_W-1:0] io_pad_oe_n,
    input wire logic [IO_W-1:0] fab_io_out,
    input wire logic [IO_W-1:0] fab_io_oe_n,
    output logic [IO_W-1:0] io_in
);
    localparam int AW = $clog2(CFG_WORDS);
    localparam int EW = GP_W - 8;
    localparam int WW = cfg_loader_pkg::CFG_WORD_W;
    localparam int CN = cfg_loader_pkg::CONN_N;
    localparam logic [AW-1:0] LAST = AW'(CFG_WORDS - 1);
    localparam logic [7:0] RST_LAST = 8'(RST_CYC - 1);

    logic [WW-1:0] cfg_mem [CFG_WORDS];
    logic [1:0] pin_sync_r;
    logic [GP_W-1:0] gp_s1_r;
    logic [GP_W-1:0] gp_s2_r;
    logic [IO_W-1:0] io_s1_r;
    logic [IO_W-1:0] io_s2_r;
    logic load_r;
    logic loaded_r;
    logic rst_busy_r;
    logic rst_done_r;
    logic [7:0] rst_cnt_r;
    logic [AW-1:0] ptr_r;
    logic [AW-1:0] rb_ptr_r;
    logic [WW-1:0] rb_r;
    logic cell_we_r;
    logic [AW-1:0] cell_addr_r;
    logic [WW-1:0] cell_data_r;
    logic [CN-1:0] conn_r;
    logic [cfg_loader_pkg::DATA_W-1:0] rdata_r;
    logic [GP_W-1:0] gp_out_r;
    logic [GP_W-1:0] gp_oe_n_r;
    logic [GP_W-1:0] chip_in_r;
    logic [EW-1:0] emu_rx_r;
    logic [3:0] irq_r;
    logic [3:0] dma_r;
    logic [IO_W-1:0] io_out_r;
    logic [IO_W-1:0] io_oe_n_r;
    logic [IO_W-1:0] io_in_r;
    logic ctrl_wr;
    logic stat_wr;
    logic start_load;
    logic push;
    logic rst_req;
    logic [WW-1:0] wr_word;

    // decode of control and status writes
    assign ctrl_wr = link.wr && (link.addr == cfg_loader_pkg::CTRL_OFS);
    assign stat_wr = link.wr && (link.addr == cfg_loader_pkg::STAT_OFS);
    assign start_load = ctrl_wr && link.wdata[cfg_loader_pkg::CTRL_LOAD_BIT]
        && !load_r;
    assign push = ctrl_wr && link.wdata[cfg_loader_pkg::CTRL_PUSH_BIT]
        && load_r && !loaded_r;
    assign rst_req = ctrl_wr && link.wdata[cfg_loader_pkg::CTRL_RST_BIT]
        && loaded_r && !rst_busy_r;
    assign wr_word = link.wdata[cfg_loader_pkg::CTRL_DATA_LSB +: WW];

    // two-stage synchronisers for pins
    always_ff @(posedge clk)
    begin
        pin_sync_r <= {pin_sync_r[0], dev_cfg_pin};
        gp_s1_r <= gp_pad_in;
        gp_s2_r <= gp_s1_r;
        io_s1_r <= io_pad_in;
        io_s2_r <= io_s1_r;
    end

    // download mode and write pointer
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            load_r <= 1'b0;
            ptr_r <= '0;
            loaded_r <= 1'b0;
        end
        else
        begin
            if (ctrl_wr) // R6
                load_r <= link.wdata[cfg_loader_pkg::CTRL_LOAD_BIT];
            if (start_load)
            begin
                ptr_r <= '0;
                loaded_r <= 1'b0;
            end
            else if (push) // R8
            begin
                ptr_r <= ptr_r + 1'b1;
                if (ptr_r == LAST) // R9
                    loaded_r <= 1'b1;
            end
        end
    end

    // cell image store, every word written once per load
    always_ff @(posedge clk)
    begin
        if (push) // R7
            cfg_mem[ptr_r] <= wr_word;
    end

    // cell load strobe toward the fabric
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cell_we_r <= 1'b0;
            cell_addr_r <= '0;
            cell_data_r <= '0;
        end
        else
        begin
            cell_we_r <= push; // R7
            if (push)
            begin
                cell_addr_r <= ptr_r;
                cell_data_r <= wr_word;
            end
        end
    end

    // readback of loaded words through the control register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rb_ptr_r <= '0;
            rb_r <= '0;
        end
        else if (start_load)
            rb_ptr_r <= '0;
        else if (ctrl_wr && link.wdata[cfg_loader_pkg::CTRL_RDBK_BIT])
        begin
            rb_r <= cfg_mem[rb_ptr_r]; // R8
            rb_ptr_r <= rb_ptr_r + 1'b1;
        end
    end

    // fabric reset routine after a complete load
    always_ff @(posedge clk)
    begin
        if (sys_rst || start_load)
        begin
            rst_busy_r <= 1'b0;
            rst_done_r <= 1'b0;
            rst_cnt_r <= '0;
        end
        else if (rst_req) // R10
        begin
            rst_busy_r <= 1'b1;
            rst_done_r <= 1'b0;
            rst_cnt_r <= '0;
        end
        else if (rst_busy_r) // R12
        begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
            if (rst_cnt_r == RST_LAST)
            begin
                rst_busy_r <= 1'b0;
                rst_done_r <= 1'b1;
            end
        end
    end

    // connection enables, refused until reset has completed
    always_ff @(posedge clk)
    begin
        if (sys_rst || start_load || rst_req)
            conn_r <= '0; // R14
        else if (stat_wr)
            conn_r <= rst_done_r ? link.wdata[CN-1:0] : '0; // R11
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rdata_r <= '0;
        else if (link.rd)
        begin
            rdata_r <= '0;
            if (link.addr == cfg_loader_pkg::CTRL_OFS)
            begin
                rdata_r[cfg_loader_pkg::CTRL_DATA_LSB +: WW] <= rb_r;
                rdata_r[cfg_loader_pkg::CTRL_LOAD_BIT] <= load_r;
            end
            else if (link.addr == cfg_loader_pkg::STAT_OFS)
            begin
                rdata_r[CN-1:0] <= conn_r;
                rdata_r[cfg_loader_pkg::STAT_LOADED_BIT] <= loaded_r;
                rdata_r[cfg_loader_pkg::STAT_RDONE_BIT] <= rst_done_r;
                rdata_r[cfg_loader_pkg::STAT_DEV_BIT] <= pin_sync_r[1];
                rdata_r[cfg_loader_pkg::STAT_RBUSY_BIT] <= rst_busy_r;
            end
        end
    end

    // general-purpose pad routing by mode
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            gp_out_r <= '0;
            gp_oe_n_r <= '1;
            chip_in_r <= '0;
            emu_rx_r <= '0;
            irq_r <= '0;
            dma_r <= '0;
        end
        else if (pin_sync_r[1]) // R1
        begin
            gp_out_r <= {8'h00, emu_tx}; // R2
            gp_oe_n_r <= {8'hFF, emu_tx_oe_n};
            chip_in_r <= '0;
            emu_rx_r <= gp_s2_r[EW-1:0]; // R3
            irq_r <= gp_s2_r[EW +: 4];
            dma_r <= gp_s2_r[EW+4 +: 4];
        end
        else
        begin
            gp_out_r <= chip_gp_out; // R13
            gp_oe_n_r <= chip_gp_oe_n;
            chip_in_r <= gp_s2_r;
            emu_rx_r <= '0;
            irq_r <= '0;
            dma_r <= '0;
        end
    end

    // dedicated I/O: fabric when enabled, external FPGA in development
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            io_out_r <= '0;
            io_oe_n_r <= '1;
            io_in_r <= '0;
        end
        else
        begin
            io_out_r <= fab_io_out;
            io_in_r <= io_s2_r; // R4
            if (!pin_sync_r[1] && conn_r[cfg_loader_pkg::CONN_IO]) // R11
                io_oe_n_r <= fab_io_oe_n;
            else
                io_oe_n_r <= '1;
        end
    end

    assign link.rdata = rdata_r;
    assign cell_we = cell_we_r;
    assign cell_addr = cell_addr_r;
    assign cell_data = cell_data_r;
    assign fab_rst = rst_busy_r;
    assign conn_en = conn_r;
    assign dev_mode = pin_sync_r[1];
    assign gp_pad_out = gp_out_r;
    assign gp_pad_oe_n = gp_oe_n_r;
    assign chip_gp_in = chip_in_r;
    assign emu_rx = emu_rx_r;
    assign emu_irq = irq_r;
    assign emu_dma = dma_r;
    assign io_pad_out = io_out_r;
    assign io_pad_oe_n = io_oe_n_r;
    assign io_in = io_in_r;
endmodule
`default_nettype wire

// file: hdl/cfg_sw_host.sv
// Purpose: loader controller driving the programming port
// Assumes: image words arrive on a valid/ready stream
// Notes: a two-entry buffer holds words while the link is busy
`timescale 1ns/1ns
`default_nettype none
module cfg_sw_host #(
    parameter int CFG_WORDS = cfg_loader_pkg::CFG_WORDS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register link
    cfg_link_if.host link,
    // software register port
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    // image word stream
    input wire logic [cfg_loader_pkg::CFG_WORD_W-1:0] bs_data,
    input wire logic bs_valid,
    output logic bs_ready
);
    localparam int WW = cfg_loader_pkg::CFG_WORD_W;
    localparam int CW = $clog2(CFG_WORDS + 1);
    typedef enum {H_IDLE, H_CLR, H_OPEN, H_PUSH, H_RST, H_PRD, H_PGAP,
        H_PWT, H_EN} hst_e;

    hst_e st_r;
    logic [WW-1:0] buf_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic [CW-1:0] sent_r;
    logic [15:0] dstat_r;
    logic [3:0] en_r;
    logic [3:0] addr_r;
    logic [31:0] wdata_r;
    logic wr_r;
    logic rd_r;
    logic [31:0] sw_rdata_r;
    logic pop;
    logic take;
    logic cmd;

    assign take = bs_valid && (cnt_r != 2'd2);
    // no pop once the image is complete, spare words stay buffered
    assign pop = (st_r == H_PUSH) && (cnt_r != 2'd0)
        && (sent_r != CW'(CFG_WORDS));
    assign cmd = sw_wr && (sw_addr == cfg_loader_pkg::HCMD_OFS);

    // two-entry image buffer
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'd0;
        end
        else
        begin
            if (take)
            begin
                buf_r[wp_r] <= bs_data;
                wp_r <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, take} - {1'b0, pop};
        end
    end

    // sequencer: download, fabric reset, enable
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= H_IDLE;
            sent_r <= '0;
            en_r <= '0;
            dstat_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
        end
        else
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            wdata_r <= '0;
            addr_r <= cfg_loader_pkg::CTRL_OFS;
            case (st_r)
                H_IDLE:
                begin
                    if (cmd && sw_wdata[cfg_loader_pkg::HCMD_LOAD_BIT])
                        st_r <= H_CLR; // R5
                    else if (cmd && sw_wdata[cfg_loader_pkg::HCMD_RST_BIT])
                        st_r <= H_RST;
                    else if (cmd && sw_wdata[cfg_loader_pkg::HCMD_EN_BIT])
                    begin
                        en_r <= sw_wdata[cfg_loader_pkg::HCMD_EN_LSB +: 4];
                        st_r <= H_EN;
                    end
                end
                H_CLR:
                begin
                    wr_r <= 1'b1;
                    st_r <= H_OPEN;
                end
                H_OPEN:
                begin
                    wr_r <= 1'b1;
                    wdata_r[cfg_loader_pkg::CTRL_LOAD_BIT] <= 1'b1;
                    sent_r <= '0;
                    st_r <= H_PUSH;
                end
                H_PUSH:
                begin
                    if (sent_r == CW'(CFG_WORDS)) // R9
                        st_r <= H_IDLE;
                    else if (pop) // R8
                    begin
                        wr_r <= 1'b1;
                        wdata_r[cfg_loader_pkg::CTRL_LOAD_BIT] <= 1'b1;
                        wdata_r[cfg_loader_pkg::CTRL_PUSH_BIT] <= 1'b1;
                        wdata_r[cfg_loader_pkg::CTRL_DATA_LSB +: WW] <=
                            buf_r[rp_r];
                        sent_r <= sent_r + 1'b1;
                    end
                end
                H_RST:
                begin
                    wr_r <= 1'b1;
                    wdata_r[cfg_loader_pkg::CTRL_RST_BIT] <= 1'b1; // R10
                    st_r <= H_PRD;
                end
                H_PRD:
                begin
                    rd_r <= 1'b1;
                    addr_r <= cfg_loader_pkg::STAT_OFS;
                    st_r <= H_PGAP;
                end
                // device latches read data on this edge
                H_PGAP:
                    st_r <= H_PWT;
                H_PWT:
                    st_r <= H_IDLE;
                H_EN:
                begin
                    wr_r <= 1'b1;
                    addr_r <= cfg_loader_pkg::STAT_OFS;
                    wdata_r[3:0] <= en_r; // R11
                    st_r <= H_PRD;
                end
                default:
                    st_r <= H_IDLE;
            endcase
            if (st_r == H_PWT)
            begin
                dstat_r <= link.rdata[15:0];
                if (link.rdata[cfg_loader_pkg::STAT_RBUSY_BIT])
                    st_r <= H_PRD;
            end
        end
    end

    // software read port
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            sw_rdata_r <= '0;
        else if (sw_rd)
        begin
            sw_rdata_r <= '0;
            if (sw_addr == cfg_loader_pkg::HSTAT_OFS)
            begin
                sw_rdata_r[cfg_loader_pkg::HSTAT_BUSY_BIT] <= st_r != H_IDLE;
                sw_rdata_r[cfg_loader_pkg::HSTAT_DEV_LSB +: 16] <= dstat_r;
            end
            else if (sw_addr == cfg_loader_pkg::HCNT_OFS)
                sw_rdata_r[CW-1:0] <= sent_r;
        end
    end

    assign link.addr = addr_r;
    assign link.wdata = wdata_r;
    assign link.wr = wr_r;
    assign link.rd = rd_r;
    assign sw_rdata = sw_rdata_r;
    assign bs_ready = cnt_r != 2'd2;
endmodule
`default_nettype wire

// file: sim/cfg_link_assertions.sv
// Purpose: protocol checks on the loader to port register link
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the link signals, instantiated beside the link
`timescale 1ns/1ns
`default_nettype none
module cfg_link_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link signals
    input wire logic [cfg_loader_pkg::ADDR_W-1:0] addr,
    input wire logic [cfg_loader_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // decoded control and status writes
    logic ctl_wr;
    logic st_wr;
    assign ctl_wr = wr && addr == cfg_loader_pkg::CTRL_OFS;
    assign st_wr = wr && addr == cfg_loader_pkg::STAT_OFS;

    a_strobe_excl: assert property (!(wr && rd))
        else $error("link read and write strobes high together");
    a_wr_mapped: assert property (wr |-> ctl_wr || st_wr)
        else $error("link write to an unmapped place");
    a_rd_single: assert property (rd |=> !rd)
        else $error("status polls not spaced");
    a_rd_status: assert property (rd |-> addr == cfg_loader_pkg::STAT_OFS)
        else $error("link read outside status");
    a_push_load: assert property
        (ctl_wr && wdata[1] |-> wdata[3:0] == 4'h3)
        else $error("word push without load level");
    a_load_order: assert property
        (ctl_wr && wdata[3:0] == 4'h1 |->
            $past(ctl_wr) && $past(wdata[3:0]) == 4'h0)
        else $error("load start not preceded by control clear");
    a_rst_poll: assert property
        (ctl_wr && wdata[2] |-> wdata[3:0] == 4'h4 ##[1:3] rd)
        else $error("fabric reset request not followed by poll");
    a_en_readback: assert property (st_wr |-> ##[1:3] rd)
        else $error("enable write not followed by status read");
endmodule
`default_nettype wire

// file: sim/custom_logic_config_loader_bench.sv
// Purpose: loader controller and programming port run end to end
// Assumes: image shrunk to 8 words on both ends
// Notes: software port tasks issue every command; config pin, pads and image stream are driven directly
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
    compares++; \
    if ((g) !== (e)) \
    begin \
        bad_count++; \
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end
module custom_logic_config_loader_bench;
    localparam int W = 8;
    localparam int GP = cfg_loader_pkg::GP_W;
    localparam int IOW = cfg_loader_pkg::FAB_IO_W;
    localparam logic [3:0] HCMD = cfg_loader_pkg::HCMD_OFS;
    localparam logic [3:0] HSTAT = cfg_loader_pkg::HSTAT_OFS;
    localparam logic [3:0] HCNT = cfg_loader_pkg::HCNT_OFS;
    int bad_count = 0;
    int compares = 0;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic [15:0] bs_data = 16'h0;
    logic bs_valid = 1'b0;
    logic bs_ready;
    logic dev_cfg_pin = 1'b0;
    logic cell_we;
    logic [$clog2(W)-1:0] cell_addr;
    logic [15:0] cell_data;
    logic fab_rst;
    logic [3:0] conn_en;
    logic dev_mode;
    logic [GP-1:0] gp_pad_in, gp_pad_out, gp_pad_oe_n;
    logic [GP-1:0] chip_gp_out, chip_gp_oe_n, chip_gp_in;
    logic [GP-9:0] emu_tx, emu_tx_oe_n, emu_rx;
    logic [3:0] emu_irq;
    logic [3:0] emu_dma;
    logic [IOW-1:0] io_pad_in, io_pad_out, io_pad_oe_n;
    logic [IOW-1:0] fab_io_out, fab_io_oe_n, io_in;
    logic [31:0] d;
    logic feed = 1'b0;
    int k = 0;
    int gap = 6;
    int ncell = 0;
    int rst_cyc = 0;
    logic [15:0] got_d [W];
    logic [$clog2(W)-1:0] got_a [W];

    cfg_link_if i_cfg_link_if ();
    fabric_prog_if #(.CFG_WORDS(W)) i_fabric_prog_if (.clk(clk),
        .sys_rst(sys_rst), .link(i_cfg_link_if), .dev_cfg_pin(dev_cfg_pin),
        .cell_we(cell_we), .cell_addr(cell_addr), .cell_data(cell_data),
        .fab_rst(fab_rst), .conn_en(conn_en), .dev_mode(dev_mode),
        .gp_pad_in(gp_pad_in), .gp_pad_out(gp_pad_out),
        .gp_pad_oe_n(gp_pad_oe_n), .chip_gp_out(chip_gp_out),
        .chip_gp_oe_n(chip_gp_oe_n), .chip_gp_in(chip_gp_in),
        .emu_tx(emu_tx), .emu_tx_oe_n(emu_tx_oe_n), .emu_rx(emu_rx),
        .emu_irq(emu_irq), .emu_dma(emu_dma), .io_pad_in(io_pad_in),
        .io_pad_out(io_pad_out), .io_pad_oe_n(io_pad_oe_n),
        .fab_io_out(fab_io_out), .fab_io_oe_n(fab_io_oe_n), .io_in(io_in));
    cfg_sw_host #(.CFG_WORDS(W)) i_cfg_sw_host (.clk(clk),
        .sys_rst(sys_rst), .link(i_cfg_link_if), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .bs_data(bs_data), .bs_valid(bs_valid),
        .bs_ready(bs_ready));
    cfg_link_assertions i_cfg_link_assertions (.clk(clk),
        .sys_rst(sys_rst), .addr(i_cfg_link_if.addr),
        .wdata(i_cfg_link_if.wdata), .wr(i_cfg_link_if.wr),
        .rd(i_cfg_link_if.rd));

    // free-running clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] word_of(input int i);
        return 16'hC3A0 + 16'(i) * 16'h0101;
    endfunction

    // image stream source with a stall in mid-image
    always @(posedge clk)
    begin
        if (bs_valid && bs_ready) k = k + 1;
        if (k == 4 && gap > 0) gap = gap - 1;
        bs_valid <= feed && k < W && !(k == 4 && gap > 0);
        bs_data <= word_of(k);
    end

    // record cell loads and fabric reset length
    always @(posedge clk)
    begin
        if (cell_we && ncell < W)
        begin
            got_d[ncell] = cell_data;
            got_a[ncell] = cell_addr;
        end
        if (cell_we) ncell++;
        if (fab_rst) rst_cyc++;
    end

    task set_pads(input logic [15:0] v);
        gp_pad_in <= {3{v}};
        chip_gp_out <= {3{~v}};
        chip_gp_oe_n <= {3{v ^ 16'h0FF0}};
        emu_tx <= {v[7:0], {2{v}}};
        emu_tx_oe_n <= {~v[7:0], {2{~v}}};
        io_pad_in <= {7{v}};
        fab_io_out <= {7{~v}};
        fab_io_oe_n <= {7{v ^ 16'hF00F}};
    endtask

    task sw_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task sw_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask

    // issue a command and poll until the controller is idle
    task run_cmd(input logic [31:0] v);
        int n;
        sw_write(HCMD, v);
        for (n = 0; n < 3000; n++)
        begin
            sw_read(HSTAT, d);
            if (d[0] === 1'b0) break;
        end
        if (n == 3000)
        begin
            bad_count++;
            complete_run();
        end
    endtask

    task chk_pads(input logic dev);
        if (dev)
        begin
            `CHK(emu_rx, gp_pad_in[39:0])
            `CHK(emu_irq, gp_pad_in[43:40])
            `CHK(emu_dma, gp_pad_in[47:44])
            `CHK(gp_pad_out[39:0], emu_tx)
            `CHK(gp_pad_oe_n[39:0], emu_tx_oe_n)
            `CHK(chip_gp_in, {GP{1'b0}})
        end
        else
        begin
            `CHK(chip_gp_in, gp_pad_in)
            `CHK(gp_pad_out, chip_gp_out)
            `CHK(gp_pad_oe_n, chip_gp_oe_n)
            `CHK(emu_irq, 4'h0)
        end
        `CHK(io_in, io_pad_in)
        `CHK(dev_mode, dev)
    endtask

    task complete_run;
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        set_pads(16'h5AC3);
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK(conn_en, 4'h0)
        `CHK(io_pad_oe_n, {IOW{1'b1}})
        chk_pads(1'b0);
        sw_read(4'hC, d);
        `CHK(d, 32'h0)
        // reset and enable refused on an empty fabric
        run_cmd(32'h2);
        `CHK(rst_cyc, 0)
        run_cmd(32'h804);
        `CHK(conn_en, 4'h0)
        // buffer fills and refuses before the download
        @(posedge clk);
        feed <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(bs_ready, 1'b0)
        `CHK(k, 2)
        run_cmd(32'h1);
        `CHK(ncell, W)
        for (int i = 0; i < W; i++)
        begin
            `CHK(got_a[i], 3'(i))
            `CHK(got_d[i], word_of(i))
        end
        sw_read(HCNT, d);
        `CHK(d, 32'(W))
        // fabric reset pulse length and status afterwards
        run_cmd(32'h2);
        `CHK(rst_cyc, cfg_loader_pkg::FAB_RST_CYC)
        sw_read(HSTAT, d);
        `CHK(d[27:24], 4'h3)
        `CHK(io_pad_oe_n, {IOW{1'b1}})
        // enable only the dedicated pad group
        run_cmd(32'h804);
        `CHK(conn_en, 4'h8)
        @(posedge clk);
        set_pads(16'h3C96);
        repeat (5) @(posedge clk);
        #1;
        `CHK(io_pad_oe_n, fab_io_oe_n)
        `CHK(io_pad_out, fab_io_out)
        chk_pads(1'b0);
        // development mode reroutes the pads
        @(posedge clk);
        dev_cfg_pin <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk_pads(1'b1);
        run_cmd(32'h804);
        sw_read(HSTAT, d);
        `CHK(d[26], 1'b1)
        complete_run();
    end
endmodule
`default_nettype wire
